// ==== core/adc_fmt_pkg.sv ====
// types shared by the converter output block
package adc_fmt_pkg;

   // ==========================================================
   // power states
   typedef enum logic [1:0] {
      PWR_NORMAL = 2'b00,
      PWR_NAP = 2'b01,
      PWR_SLEEP = 2'b10
   } power_e;

   // ==========================================================
   // one converted sample travelling down the pipeline
   typedef struct packed {
      logic valid;
      logic ovr;
      logic [11:0] word;
   } sample_s;

endpackage : adc_fmt_pkg

// ==== core/adc_fmt_regs.svh ====
// register map, field positions, reset values and timing counts of the converter output block
`ifndef ADC_FMT_REGS_SVH
`define ADC_FMT_REGS_SVH

// ==========================================================
// register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_INT_STATUS 12'h008
`define OFS_INT_MASK 12'h00c
`define OFS_LAST_SAMPLE 12'h010
`define OFS_OVR_COUNT 12'h014

// ==========================================================
// field positions
`define CTRL_CONV_EN_BIT 0
`define ST_LEVEL_LSB 0
`define ST_LEVEL_MSB 1
`define ST_DCS_BIT 2
`define ST_TWOS_BIT 3
`define ST_PWR_LSB 4
`define ST_PWR_MSB 5
`define ST_SETTLED_BIT 6
`define LS_OVR_BIT 12
`define EVT_OVR_BIT 0
`define EVT_SLEEP_BIT 1
`define EVT_NAP_BIT 2
`define EVT_SETTLED_BIT 3
`define EVT_WIDTH 4

// ==========================================================
// reset values
`define CTRL_RESET 32'h0000_0001
`define INT_MASK_RESET 4'h0
`define WORD_RESET 12'h000

// ==========================================================
// configuration pin levels
`define LVL_GND 2'h0
`define LVL_THIRD 2'h1
`define LVL_TWO_THIRDS 2'h2
`define LVL_SUPPLY 2'h3

// ==========================================================
// output codes and input limits
`define WORD_MID 12'h800
`define WORD_POS_FS 12'hfff
`define WORD_NEG_FS 12'h000
`define MSB_FLIP 12'h800
`define RAW_POS_LIM 14'sh07ff
`define RAW_NEG_LIM 14'sh3800
`define RAW_OFFSET 14'sh0800

// ==========================================================
// timing
`define CLK_MHZ 50
`define REF_RECOVERY_US 1000
`define REF_RECOVERY_CYC (`REF_RECOVERY_US * `CLK_MHZ)
`define PIPE_LATENCY_DEF 5

`endif

// ==== core/adc_output_core.sv ====
// output coding, power states, tri-state control and apb registers of the converter
//
// Contract
// - sample taken on conversion clock rising edge
// - stabilizer on: falling edge never affects sampling
// - stabilizer on only at 1/3 or 2/3 level
// - ground or 1/3 offset binary, else twos
// - offset binary: mid 800, ends fff/000
// - twos complement is offset binary msb flipped
// - overrange sets flag, word clamped full scale
// - output enable high tri-states data and flag
// - shutdown low gives normal conversion
// - shutdown and enable high give sleep
// - shutdown high, enable low gives nap
`timescale 1ns/1ps
`include "adc_fmt_regs.svh"
module adc_output_core #(
   parameter int PIPE_LATENCY = `PIPE_LATENCY_DEF,
   parameter int REF_WAIT = `REF_RECOVERY_CYC
) (
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // converter pins
   input wire logic signed [13:0] analog_level,
   input wire logic [1:0] config_level,
   input wire logic power_down_select,
   input wire logic output_enable_n,
   // sample outputs
   output logic [11:0] sample_word_bits,
   output logic sample_word_oe,
   output logic overrange_flag,
   output logic overrange_oe,
   // interrupt
   output logic irq
);

   // ==========================================================
   // decode helpers
   function automatic logic dcs_active(input logic [1:0] lvl);
      dcs_active = (lvl == `LVL_THIRD) || (lvl == `LVL_TWO_THIRDS);
   endfunction : dcs_active

   function automatic logic twos_format(input logic [1:0] lvl);
      twos_format = (lvl == `LVL_TWO_THIRDS) || (lvl == `LVL_SUPPLY);
   endfunction : twos_format

   function automatic logic [11:0] offset_code(input logic signed [13:0] raw);
      logic signed [13:0] sum;
      sum = raw + `RAW_OFFSET;
      if (raw > `RAW_POS_LIM) begin
         offset_code = `WORD_POS_FS;
      end else if (raw < `RAW_NEG_LIM) begin
         offset_code = `WORD_NEG_FS;
      end else begin
         offset_code = sum[11:0];
      end
   endfunction : offset_code

   // ==========================================================
   // state
   logic [31:0] ctrl_q;
   logic [1:0] cfg_q;
   adc_fmt_pkg::power_e power_q;
   adc_fmt_pkg::power_e power_d;
   logic settled_q;
   logic [16:0] wait_q;
   adc_fmt_pkg::sample_s capture_q;
   adc_fmt_pkg::sample_s pipe_out;
   logic [11:0] word_q;
   logic ovr_q;
   logic oe_q;
   logic [`EVT_WIDTH-1:0] int_q;
   logic [`EVT_WIDTH-1:0] mask_q;
   logic [`EVT_WIDTH-1:0] evt;
   logic [`EVT_WIDTH-1:0] int_clr;
   logic irq_q;
   logic [12:0] last_q;
   logic [15:0] ovr_cnt_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] rd_mux;
   logic mapped;
   logic access;
   logic commit;
   logic wr_commit;
   logic sample_en;
   logic [11:0] ob_code;
   logic raw_over;
   logic settle_done;

   // ==========================================================
   // configuration pin and power state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= `LVL_GND;
      end else begin
         cfg_q <= config_level;
      end
   end

   always_comb begin
      power_d = power_q;
      case (power_q)
         adc_fmt_pkg::PWR_NORMAL: begin
            if (power_down_select) begin
               power_d = output_enable_n ? adc_fmt_pkg::PWR_SLEEP : adc_fmt_pkg::PWR_NAP;
            end
         end
         adc_fmt_pkg::PWR_NAP: begin
            if (!power_down_select) begin
               power_d = adc_fmt_pkg::PWR_NORMAL;
            end else if (output_enable_n) begin
               power_d = adc_fmt_pkg::PWR_SLEEP;
            end
         end
         adc_fmt_pkg::PWR_SLEEP: begin
            if (!power_down_select) begin
               power_d = adc_fmt_pkg::PWR_NORMAL;
            end else if (!output_enable_n) begin
               power_d = adc_fmt_pkg::PWR_NAP;
            end
         end
         default: begin
            power_d = adc_fmt_pkg::PWR_NORMAL;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_q <= adc_fmt_pkg::PWR_NORMAL;
      end else begin
         power_q <= power_d;
      end
   end

   // ==========================================================
   // reference recovery after sleep; conversion keeps running, the flag only tells
   // the capture side when samples become trustworthy again
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settled_q <= 1'b1;
         wait_q <= '0;
      end else if (power_d == adc_fmt_pkg::PWR_SLEEP) begin
         settled_q <= 1'b0;
         wait_q <= 17'(REF_WAIT - 1);
      end else if (!settled_q) begin
         if (wait_q == '0) begin
            settled_q <= 1'b1;
         end else begin
            wait_q <= wait_q - 17'h0_0001;
         end
      end
   end

   assign settle_done = !settled_q && (wait_q == '0) && (power_d != adc_fmt_pkg::PWR_SLEEP);

   // ==========================================================
   // sampling and coding; only the rising edge is ever used, so clock high time
   // cannot shift the sampling instant whichever way the stabilizer is set
   assign sample_en = (power_q == adc_fmt_pkg::PWR_NORMAL) && ctrl_q[`CTRL_CONV_EN_BIT];
   assign ob_code = offset_code(analog_level);
   assign raw_over = (analog_level > `RAW_POS_LIM) || (analog_level < `RAW_NEG_LIM);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_q <= '0;
      end else begin
         capture_q.valid <= sample_en;
         capture_q.ovr <= raw_over;
         capture_q.word <= twos_format(cfg_q) ? (ob_code ^ `MSB_FLIP) : ob_code;
      end
   end

   adc_sample_pipe #(
      .DEPTH(PIPE_LATENCY - 2)
   ) i_adc_sample_pipe (
      .pclk(pclk),
      .presetn(presetn),
      .din(capture_q),
      .dout(pipe_out)
   );

   // ==========================================================
   // output drivers; enable is not gated by sample timing, toggling it per sample
   // is the capture side's mistake to avoid
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_q <= `WORD_RESET;
         ovr_q <= 1'b0;
      end else if (pipe_out.valid) begin
         word_q <= pipe_out.word;
         ovr_q <= pipe_out.ovr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= !output_enable_n && !power_down_select;
      end
   end

   // ==========================================================
   // events and interrupt
   assign evt[`EVT_OVR_BIT] = pipe_out.valid && pipe_out.ovr;
   assign evt[`EVT_SLEEP_BIT] = (power_d == adc_fmt_pkg::PWR_SLEEP) &&
                                (power_q != adc_fmt_pkg::PWR_SLEEP);
   assign evt[`EVT_NAP_BIT] = (power_d == adc_fmt_pkg::PWR_NAP) &&
                              (power_q != adc_fmt_pkg::PWR_NAP);
   assign evt[`EVT_SETTLED_BIT] = settle_done;

   assign int_clr = (wr_commit && paddr == `OFS_INT_STATUS) ? pwdata[`EVT_WIDTH-1:0] : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_q <= '0;
      end else begin
         int_q <= (int_q & ~int_clr) | evt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(((int_q & ~int_clr) | evt) & mask_q);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_q <= '0;
         ovr_cnt_q <= '0;
      end else if (pipe_out.valid) begin
         last_q <= {pipe_out.ovr, pipe_out.word};
         if (pipe_out.ovr && ovr_cnt_q != 16'hffff) begin
            ovr_cnt_q <= ovr_cnt_q + 16'h0001;
         end
      end
   end

   // ==========================================================
   // apb slave: one wait state so read data leaves a flop
   assign access = psel && penable;
   assign commit = access && pready_q;
   assign wr_commit = commit && pwrite;

   always_comb begin
      rd_mux = '0;
      mapped = 1'b1;
      case (paddr)
         `OFS_CTRL: begin
            rd_mux = ctrl_q;
         end
         `OFS_STATUS: begin
            rd_mux[`ST_LEVEL_MSB:`ST_LEVEL_LSB] = cfg_q;
            rd_mux[`ST_DCS_BIT] = dcs_active(cfg_q);
            rd_mux[`ST_TWOS_BIT] = twos_format(cfg_q);
            rd_mux[`ST_PWR_MSB:`ST_PWR_LSB] = power_q;
            rd_mux[`ST_SETTLED_BIT] = settled_q;
         end
         `OFS_INT_STATUS: begin
            rd_mux[`EVT_WIDTH-1:0] = int_q;
         end
         `OFS_INT_MASK: begin
            rd_mux[`EVT_WIDTH-1:0] = mask_q;
         end
         `OFS_LAST_SAMPLE: begin
            rd_mux[`LS_OVR_BIT:0] = last_q;
         end
         `OFS_OVR_COUNT: begin
            rd_mux[15:0] = ovr_cnt_q;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= access && !pready_q;
         pslverr_q <= access && !pready_q && !mapped;
         prdata_q <= (access && !pready_q && !pwrite) ? rd_mux : '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `CTRL_RESET;
         mask_q <= `INT_MASK_RESET;
      end else if (wr_commit) begin
         if (paddr == `OFS_CTRL) begin
            ctrl_q <= pwdata & 32'h0000_0001;
         end
         if (paddr == `OFS_INT_MASK) begin
            mask_q <= pwdata[`EVT_WIDTH-1:0];
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign sample_word_bits = word_q;
   assign overrange_flag = ovr_q;
   assign sample_word_oe = oe_q;
   assign overrange_oe = oe_q;
   assign irq = irq_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence sleep_held_s;
      power_q == adc_fmt_pkg::PWR_SLEEP;
   endsequence

   sequence sleep_left_s;
      power_q == adc_fmt_pkg::PWR_NORMAL;
   endsequence

   sample_on_edge_a: assert property (presetn |=> capture_q.valid == $past(sample_en))
      else $error("capture valid does not follow sample enable");
   dcs_status_a: assert property ((pready && !pwrite && paddr == `OFS_STATUS) |->
      prdata[`ST_DCS_BIT] == (prdata[1:0] == `LVL_THIRD || prdata[1:0] == `LVL_TWO_THIRDS))
      else $error("stabilizer status bit wrong");
   mid_code_a: assert property ((presetn && analog_level == 14'sh0000 &&
      !twos_format(cfg_q)) |=> capture_q.word == `WORD_MID)
      else $error("zero input not at mid code");
   twos_flip_a: assert property (twos_format(cfg_q) && $stable(cfg_q)
      |=> capture_q.word == ($past(ob_code) ^ `MSB_FLIP))
      else $error("twos code not msb flipped");
   ob_format_a: assert property ((presetn && !twos_format(cfg_q))
      |=> capture_q.word == $past(ob_code))
      else $error("offset binary format wrong");
   clamp_pos_a: assert property ((analog_level > `RAW_POS_LIM && !twos_format(cfg_q))
      |=> capture_q.ovr && capture_q.word == `WORD_POS_FS)
      else $error("positive overrange not clamped");
   oe_hiz_a: assert property (output_enable_n |=> !sample_word_oe && !overrange_oe)
      else $error("outputs driven while enable high");
   normal_mode_a: assert property (!power_down_select |=> power_q == adc_fmt_pkg::PWR_NORMAL)
      else $error("not normal with shutdown low");
   sleep_mode_a: assert property ((power_down_select && output_enable_n)
      |=> power_q == adc_fmt_pkg::PWR_SLEEP)
      else $error("sleep not entered");
   nap_mode_a: assert property ((power_down_select && !output_enable_n)
      |=> power_q == adc_fmt_pkg::PWR_NAP && !sample_word_oe)
      else $error("nap not entered or outputs driven");
   wake_unsettled_a: assert property (sleep_held_s ##1 sleep_left_s |-> !settled_q)
      else $error("settled flag set right after sleep");
   pipe_latency_a: assert property (pipe_out == $past(capture_q, PIPE_LATENCY - 2))
      else $error("pipeline latency wrong");

endmodule : adc_output_core

// ==== core/adc_sample_pipe.sv ====
// fixed-depth delay line for converted samples
`timescale 1ns/1ps
module adc_sample_pipe #(
   parameter int DEPTH = 3
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // samples
   input adc_fmt_pkg::sample_s din,
   output adc_fmt_pkg::sample_s dout
);

   adc_fmt_pkg::sample_s stage_q [DEPTH];

   // ==========================================================
   // stages
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_stage
         // head and tail split so the tail's index never points below zero
         if (g == 0) begin : g_head
            always_ff @(posedge pclk or negedge presetn) begin
               if (!presetn) begin
                  stage_q[g] <= '0;
               end else begin
                  stage_q[g] <= din;
               end
            end
         end else begin : g_tail
            always_ff @(posedge pclk or negedge presetn) begin
               if (!presetn) begin
                  stage_q[g] <= '0;
               end else begin
                  stage_q[g] <= stage_q[g-1];
               end
            end
         end
      end
   endgenerate

   assign dout = stage_q[DEPTH-1];

endmodule : adc_sample_pipe

// ==== tb/adc_output_format_and_power_modes_test.sv ====
// self-checking bench of the converter output coding and power block
`timescale 1ns/1ps
`include "adc_fmt_regs.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module adc_output_format_and_power_modes_test;
   localparam int PIPE = 5;
   localparam int REFW = 20;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr, sample_word_bits, data_wire;
   logic [31:0] pwdata, prdata, r;
   logic signed [13:0] analog_level;
   logic [1:0] config_level;
   logic power_down_select, output_enable_n, sample_word_oe, overrange_flag, overrange_oe;
   logic flag_wire, sample_valid;
   int fail_count, comparisons;
   int vals[7] = '{0, 1, -1, 2047, -2048, 2100, -2100};

   // ==========================================================
   // instances
   adc_output_core #(.PIPE_LATENCY(PIPE), .REF_WAIT(REFW)) i_adc_output_core (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .analog_level(analog_level), .config_level(config_level),
      .power_down_select(power_down_select), .output_enable_n(output_enable_n),
      .sample_word_bits(sample_word_bits), .sample_word_oe(sample_word_oe),
      .overrange_flag(overrange_flag), .overrange_oe(overrange_oe), .irq(irq));
   sample_capture_model #(.SETTLE(REFW)) i_sample_capture_model (
      .pclk(pclk), .presetn(presetn), .sample_word_bits(sample_word_bits),
      .sample_word_oe(sample_word_oe), .overrange_flag(overrange_flag),
      .overrange_oe(overrange_oe), .sleep_req(power_down_select & output_enable_n),
      .data_wire(data_wire), .flag_wire(flag_wire), .sample_valid(sample_valid));

   // ==========================================================
   // clock: steady 50% duty, well above the minimum rate
   always #10 pclk = ~pclk;

   // ==========================================================
   // helpers
   function automatic logic [11:0] exp_word(input int lvl, input int cfg);
      logic [11:0] w;
      if (lvl > 2047) w = 12'hfff;
      else if (lvl < -2048) w = 12'h000;
      else w = 12'(lvl + 2048);
      if (cfg >= 2) w = w ^ 12'h800;
      return w;
   endfunction : exp_word

   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] rd, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no fixed wait count: a slave that never answers is left to the watchdog
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      logic e;
      apb(a, 1'b0, 32'h0000_0000, v, e);
   endtask : rd

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] v;
      logic e;
      apb(a, 1'b1, d, v, e);
   endtask : wr

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   // ==========================================================
   // scenarios
   task automatic t_reset;
      logic e;
      rd(`OFS_CTRL, r);
      `CHK(r, 32'h0000_0001)
      rd(`OFS_INT_MASK, r);
      `CHK(r[3:0], 4'h0)
      apb(12'h100, 1'b0, 32'h0000_0000, r, e);
      `CHK({e, r}, {1'b1, 32'h0000_0000})
      `CHK(irq, 1'b0)
   endtask : t_reset

   task automatic t_latency;
      int n;
      n = 0;
      cyc(PIPE + 4);
      @(negedge pclk);
      `CHK(data_wire, 12'h800)
      @(posedge pclk);
      analog_level <= 14'sd100;
      do begin
         @(negedge pclk);
         n++;
      end while (data_wire !== 12'h864 && n < 40);
      `CHK(n, PIPE + 1)
   endtask : t_latency

   task automatic t_coding;
      for (int c = 0; c < 4; c++) begin
         @(posedge pclk);
         config_level <= 2'(c);
         for (int i = 0; i < 7; i++) begin
            @(posedge pclk);
            analog_level <= 14'(vals[i]);
            cyc(PIPE + 3);
            @(negedge pclk);
            `CHK(data_wire, exp_word(vals[i], c))
            `CHK(flag_wire, 1'(vals[i] > 2047 || vals[i] < -2048))
         end
         rd(`OFS_STATUS, r);
         `CHK(r[3:2], {1'(c >= 2), 1'(c == 1 || c == 2)})
         rd(`OFS_LAST_SAMPLE, r);
         `CHK(r[12:0], {1'b1, exp_word(-2100, c)})
      end
   endtask : t_coding

   task automatic t_irq;
      @(posedge pclk);
      config_level <= 2'd0;
      analog_level <= 14'sd0;
      cyc(PIPE + 3);
      wr(`OFS_INT_STATUS, 32'h0000_000f);
      wr(`OFS_INT_MASK, 32'h0000_0001);
      `CHK(irq, 1'b0)
      @(posedge pclk);
      analog_level <= 14'sd3000;
      @(posedge pclk);
      analog_level <= 14'sd0;
      cyc(PIPE + 4);
      `CHK(irq, 1'b1)
      rd(`OFS_INT_STATUS, r);
      `CHK(r[0], 1'b1)
      wr(`OFS_INT_STATUS, 32'h0000_0001);
      rd(`OFS_INT_STATUS, r);
      `CHK({irq, r[3:0]}, 5'h00)
      // masked event still latches status but leaves the line low
      wr(`OFS_INT_MASK, 32'h0000_0000);
      @(posedge pclk);
      analog_level <= -14'sd3000;
      @(posedge pclk);
      analog_level <= 14'sd0;
      cyc(PIPE + 4);
      rd(`OFS_INT_STATUS, r);
      `CHK({irq, r[0]}, 2'b01)
      // conversion stopped: outputs hold, then resume with the new level
      wr(`OFS_CTRL, 32'h0000_0000);
      @(posedge pclk);
      analog_level <= 14'sd100;
      cyc(PIPE + 3);
      @(negedge pclk);
      `CHK(data_wire, 12'h800)
      wr(`OFS_CTRL, 32'h0000_0001);
      cyc(PIPE + 3);
      @(negedge pclk);
      `CHK(data_wire, 12'h864)
   endtask : t_irq

   task automatic t_power;
      wr(`OFS_INT_STATUS, 32'h0000_000f);
      @(posedge pclk);
      output_enable_n <= 1'b1;
      cyc(4);
      `CHK({sample_word_oe, overrange_oe}, 2'b00)
      `CHK({flag_wire, data_wire}, {1'b1, 12'h79b})
      rd(`OFS_STATUS, r);
      `CHK(r[5:4], 2'b00)
      @(posedge pclk);
      power_down_select <= 1'b1;
      cyc(3);
      rd(`OFS_STATUS, r);
      `CHK(r[5:4], 2'b10)
      rd(`OFS_INT_STATUS, r);
      `CHK(r[1], 1'b1)
      @(posedge pclk);
      power_down_select <= 1'b0;
      output_enable_n <= 1'b0;
      cyc(2);
      `CHK(sample_valid, 1'b0)
      rd(`OFS_STATUS, r);
      `CHK({r[6], r[5:4]}, 3'b000)
      cyc(REFW + 5);
      rd(`OFS_STATUS, r);
      `CHK(r[6], 1'b1)
      rd(`OFS_INT_STATUS, r);
      `CHK(r[3], 1'b1)
      `CHK({sample_word_oe, overrange_oe, sample_valid}, 3'b111)
      @(posedge pclk);
      power_down_select <= 1'b1;
      cyc(3);
      `CHK({sample_word_oe, overrange_oe}, 2'b00)
      rd(`OFS_STATUS, r);
      `CHK({r[6], r[5:4]}, 3'b101)
      rd(`OFS_INT_STATUS, r);
      `CHK(r[2], 1'b1)
      @(posedge pclk);
      power_down_select <= 1'b0;
      cyc(3);
      `CHK({sample_word_oe, overrange_oe}, 2'b11)
   endtask : t_power

   // ==========================================================
   // run control
   task automatic final_report;
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite} = 3'b000;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      analog_level = 14'sd0;
      config_level = 2'd0;
      power_down_select = 1'b0;
      output_enable_n = 1'b0;
      fail_count = 0;
      comparisons = 0;
      cyc(3);
      presetn <= 1'b1;
      t_reset();
      t_latency();
      t_coding();
      t_irq();
      t_power();
      final_report();
   end

   // watchdog: whole run needs a few hundred cycles
   initial begin
      cyc(20000);
      fail_count++;
      final_report();
   end

endmodule : adc_output_format_and_power_modes_test

// ==== tb/sample_capture_model.sv ====
// capture-side model of the logic that reads the converter's parallel outputs
`timescale 1ns/1ps
module sample_capture_model #(
   parameter int SETTLE = 20
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // converter outputs and sleep request
   input wire logic [11:0] sample_word_bits,
   input wire logic sample_word_oe,
   input wire logic overrange_flag,
   input wire logic overrange_oe,
   input wire logic sleep_req,
   // resolved pins and trust flag
   output logic [11:0] data_wire,
   output logic flag_wire,
   output logic sample_valid
);
   logic [11:0] last_word_q;
   logic last_flag_q;
   int settle_q;

   // ==========================================================
   // pins
   // no pull on the data lines: undriven pins show the inverse of the last driven value
   assign data_wire = sample_word_oe ? sample_word_bits : ~last_word_q;
   assign flag_wire = overrange_oe ? overrange_flag : ~last_flag_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_word_q <= 12'h000;
         last_flag_q <= 1'b0;
      end else if (sample_word_oe) begin
         last_word_q <= sample_word_bits;
         last_flag_q <= overrange_flag;
      end
   end

   // ==========================================================
   // trust window
   // reference recharges after sleep, so samples are ignored for a while
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_q <= 0;
      end else if (sleep_req) begin
         settle_q <= SETTLE;
      end else if (settle_q != 0) begin
         settle_q <= settle_q - 1;
      end
   end
   assign sample_valid = (settle_q == 0) && !sleep_req;

endmodule : sample_capture_model
